// file: logic/iswt_top.sv
// Interval and square wave timer with pin routing and APB registers
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module iswt_top (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [iswt_pkg::ISWT_AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Pins and neighbouring blocks
  input  wire iswt_pkg::iswt_pin_in_t pins_in,
  output iswt_pkg::iswt_pin_out_t     pins_out
);
  import iswt_pkg::*;

  typedef struct packed {
    logic [7:0]    pdir;
    logic [7:0]    insw;
    logic [7:0]    prm;
    logic [7:0]    toc;
    logic [7:0]    tmc;
    logic [15:0]   cra;
    logic [15:0]   crb;
    logic [15:0]   cnt;
    logic [7:0]    presc;
    logic [1:0]    ti_s;
    logic          ti_lvl;
    logic          sub_q;
    logic          aux_q;
    logic          tout;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    iswt_pin_out_t pout;
  } iswt_state_t;

  iswt_state_t st;
  iswt_state_t next_st;
  logic        tick;
  logic        wr;
  logic        rx_sel;
  logic        ti_raw;
  logic        ti_rise;
  logic        ti_fall;
  logic        ti_stable;
  iswt_mode_t  mode;

  function automatic logic addr_is(input logic [ISWT_AW-1:0] a,
                                   input logic [15:0] idx);
    addr_is = (a == {idx, 2'b00});
  endfunction

  function automatic logic mapped(input logic [ISWT_AW-1:0] a);
    mapped = addr_is(a, IDX_PDIR) || addr_is(a, IDX_INSW) ||
             addr_is(a, IDX_PRM) || addr_is(a, IDX_TOC) ||
             addr_is(a, IDX_TMC) || addr_is(a, IDX_CRA) ||
             addr_is(a, IDX_CRB) || addr_is(a, IDX_CNT);
  endfunction

  always_comb begin
    next_st   = st;
    mode      = iswt_mode_t'(st.tmc[TMC_MODE_LO+:2]);
    // Serial pin pair and receive source
    rx_sel    = 1'b1;
    next_st.pout.serial_pri_tx_pin = 1'b1;
    next_st.pout.serial_pri_tx_oe  = 1'b0;
    next_st.pout.serial_alt_tx_pin = 1'b1;
    next_st.pout.serial_alt_tx_oe  = 1'b0;
    if (st.insw[INSW_SER_LO+:2] == SER_PRIMARY) begin
      next_st.pout.serial_pri_tx_pin = pins_in.serial_tx_output;
      next_st.pout.serial_pri_tx_oe  = 1'b1;
      // Disabled receive pin reads as idle line
      rx_sel = st.insw[INSW_RXEN] ? pins_in.serial_pri_rx_pin : 1'b1;
    end else if (st.insw[INSW_SER_LO+:2] == SER_ALT) begin
      next_st.pout.serial_alt_tx_pin = pins_in.serial_tx_output;
      next_st.pout.serial_alt_tx_oe  = 1'b1;
      rx_sel = pins_in.serial_alt_rx_pin;
    end
    next_st.pout.serial_rx_input = rx_sel;
    next_st.pout.ext_irq0_input  = st.insw[INSW_IRQ0] ? rx_sel :
                                   pins_in.ext_irq0_pin;
    next_st.pout.aux_timer_input = st.insw[INSW_AUX] ?
      (pins_in.port3_pin4 & pins_in.gating_timer_output) :
      pins_in.port3_pin4;
    ti_raw = st.insw[INSW_TI] ? rx_sel : pins_in.port3_pin3;

    // Edge accepted only after two equal samples, filtering short noise
    next_st.ti_s = {st.ti_s[0], ti_raw};
    ti_stable    = (st.ti_s[1] == st.ti_s[0]);
    ti_rise      = ti_stable && st.ti_s[0] && !st.ti_lvl;
    ti_fall      = ti_stable && !st.ti_s[0] && st.ti_lvl;
    if (ti_stable) begin
      next_st.ti_lvl = st.ti_s[0];
    end
    next_st.sub_q = pins_in.subsys_clk;
    next_st.aux_q = pins_in.aux_8bit_timer;
    next_st.presc = st.presc + 8'h01;

    unique case (iswt_clk_src_t'(st.prm[2:0]))
      CLK_FPRS:      tick = 1'b1;
      CLK_DIV2:      tick = st.presc[0];
      CLK_DIV4:      tick = &st.presc[1:0];
      CLK_DIV16:     tick = &st.presc[3:0];
      CLK_DIV256:    tick = &st.presc;
      CLK_SUB:       tick = pins_in.subsys_clk && !st.sub_q;
      CLK_TI_EDGE: begin
        unique case (st.prm[PRM_ES_LO+:2])
          ES_FALL: tick = ti_fall;
          ES_RISE: tick = ti_rise;
          ES_BOTH: tick = ti_rise || ti_fall;
          default: tick = 1'b0;
        endcase
      end
      CLK_AUX_TIMER: tick = pins_in.aux_8bit_timer && !st.aux_q;
    endcase

    // Counter and compare
    next_st.pout.match_a_irq = 1'b0;
    next_st.pout.match_b_irq = 1'b0;
    if (mode == MODE_STOP) begin
      next_st.cnt = 16'h0000;
    end else if (tick) begin
      next_st.pout.match_a_irq = (st.cnt == st.cra);
      next_st.pout.match_b_irq = (st.cnt == st.crb);
      if (mode == MODE_MATCH_CLR && st.cnt == st.cra) begin
        next_st.cnt = 16'h0000;
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end
    if (next_st.pout.match_a_irq && st.toc[TOC_INV_A]) begin
      next_st.tout = !next_st.tout;
    end
    if (next_st.pout.match_b_irq && st.toc[TOC_INV_B]) begin
      next_st.tout = !next_st.tout;
    end

    // APB: setup cycle arms pready, access cycle completes
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    wr = psel && penable && st.pready && pwrite && !st.pslverr;
    if (psel && !penable && !st.pready) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !mapped(paddr);
      next_st.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        if (addr_is(paddr, IDX_PDIR)) begin
          next_st.prdata[7:0] = st.pdir;
        end
        if (addr_is(paddr, IDX_INSW)) begin
          next_st.prdata[7:0] = st.insw;
        end
        if (addr_is(paddr, IDX_PRM)) begin
          next_st.prdata[7:0] = st.prm;
        end
        if (addr_is(paddr, IDX_TOC)) begin
          next_st.prdata[7:0] = st.toc;
        end
        if (addr_is(paddr, IDX_TMC)) begin
          next_st.prdata[7:0] = st.tmc;
        end
        if (addr_is(paddr, IDX_CRA)) begin
          next_st.prdata[15:0] = st.cra;
        end
        if (addr_is(paddr, IDX_CRB)) begin
          next_st.prdata[15:0] = st.crb;
        end
        if (addr_is(paddr, IDX_CNT)) begin
          next_st.prdata[15:0] = st.cnt;
        end
      end
    end
    if (wr) begin
      if (addr_is(paddr, IDX_PDIR)) begin
        next_st.pdir = (pwdata[7:0] & PDIR_WMASK) | PDIR_FIXED;
      end
      if (addr_is(paddr, IDX_INSW)) begin
        next_st.insw = pwdata[7:0] & INSW_WMASK;
      end
      if (addr_is(paddr, IDX_PRM)) begin
        next_st.prm = pwdata[7:0] & PRM_WMASK;
      end
      if (addr_is(paddr, IDX_TMC)) begin
        next_st.tmc = pwdata[7:0] & TMC_WMASK;
      end
      if (addr_is(paddr, IDX_CRA)) begin
        next_st.cra = pwdata[15:0];
      end
      if (addr_is(paddr, IDX_CRB)) begin
        next_st.crb = pwdata[15:0];
      end
      if (addr_is(paddr, IDX_TOC)) begin
        // Level set and reset bits act once and are not stored
        next_st.toc = pwdata[7:0] & TOC_WMASK;
        if (pwdata[TOC_LVS]) begin
          next_st.tout = 1'b1;
        end else if (pwdata[TOC_LVR]) begin
          next_st.tout = 1'b0;
        end
      end
    end

    next_st.pout.port3_oe      = ~next_st.pdir[4:1];
    next_st.pout.timer_out_pin = next_st.toc[TOC_TOE] && next_st.tout;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st       <= '0;
      st.pdir  <= PDIR_RST;
      st.insw  <= INSW_RST;
      st.prm   <= PRM_RST;
      st.toc   <= TOC_RST;
      st.tmc   <= TMC_RST;
      st.ti_s  <= 2'h3;
      st.ti_lvl <= 1'b1;
      st.pout.port3_oe <= 4'h0;
      st.pout.serial_rx_input <= 1'b1;
      st.pout.serial_pri_tx_pin <= 1'b1;
      st.pout.serial_alt_tx_pin <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata   = st.prdata;
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign pins_out = st.pout;

  // Checks on reset values, counting, compare, pin routing and register reads
  dir_reset_a: assert property (
    @(posedge core_clk) $rose(rst_n) |-> st.pdir == 8'hff &&
      pins_out.port3_oe == 4'h0)
    else $error("direction register not all ones after reset");

  insw_reset_a: assert property (
    @(posedge core_clk) $rose(rst_n) |-> st.insw == 8'h00)
    else $error("input switch register not zero after reset");

  port_oe_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    pins_out.port3_oe == ~st.pdir[4:1])
    else $error("pin drive does not follow direction bits");

  stop_clear_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st.tmc[3:2] == 2'h0) ##1 (st.tmc[3:2] == 2'h0) |-> st.cnt == 16'h0000)
    else $error("counter not zero while stopped");

  match_clear_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st.tmc[3:2] == 2'h3 && tick && st.cnt == st.cra) |=>
      (st.cnt == 16'h0000 && pins_out.match_a_irq))
    else $error("match A did not clear counter and raise interrupt");

  count_inc_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st.tmc[3:2] != 2'h0 && tick && !wr &&
     !(st.tmc[3:2] == 2'h3 && st.cnt == st.cra)) |=>
      st.cnt == $past(st.cnt) + 16'h0001)
    else $error("counter did not advance on a tick");

  fprs_tick_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st.prm[2:0] == 3'h0 && st.tmc[3:2] == 2'h1 && !wr) [*2] |->
      st.cnt == $past(st.cnt) + 16'h0001)
    else $error("undivided clock does not tick every cycle");

  match_b_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st.tmc[3:2] != 2'h0 && tick && st.cnt == st.crb) |=>
      pins_out.match_b_irq)
    else $error("match B interrupt missing");

  square_toggle_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (pins_out.match_a_irq && st.toc[1:0] == 2'h3 && !st.toc[4] &&
     !$past(wr)) |-> pins_out.timer_out_pin != $past(pins_out.timer_out_pin))
    else $error("timer output not inverted on match A");

  ti_route_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (!st.insw[1] && !wr) ##1 !st.insw[1] |->
      st.ti_s[0] == $past(pins_in.port3_pin3))
    else $error("timer input not taken from its pin");

  irq0_route_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !$past(st.insw[0]) && $past(rst_n) |->
      pins_out.ext_irq0_input == $past(pins_in.ext_irq0_pin))
    else $error("interrupt 0 input not from its pin");

  tx_route_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.insw[5:4] == 2'h2 |=> pins_out.serial_alt_tx_oe &&
      !pins_out.serial_pri_tx_oe &&
      pins_out.serial_alt_tx_pin == $past(pins_in.serial_tx_output))
    else $error("serial transmit not on alternate pins");

  rx_off_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.insw[5:3] == 3'h0 |=> pins_out.serial_rx_input)
    else $error("disabled receive pin not idle");

  aux_gate_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.insw[2] |=> pins_out.aux_timer_input ==
      ($past(pins_in.port3_pin4) && $past(pins_in.gating_timer_output)))
    else $error("aux timer input not gated");

  tout_gate_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !st.toc[0] |-> !pins_out.timer_out_pin)
    else $error("timer output driven while disabled");

  cnt_read_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (psel && !penable && !st.pready && !pwrite &&
     paddr == {IDX_CNT, 2'b00}) |=> prdata[15:0] == $past(st.cnt))
    else $error("counter read returned a wrong value");

  start_count_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (st.tmc[3:2] == 2'h0) ##1 (st.tmc[3:2] == 2'h3 && tick &&
      st.cra != 16'h0000) |=> st.cnt == 16'h0001)
    else $error("counting did not start with the count clock");

  cov_match_a: cover property (@(posedge core_clk) disable iff (!rst_n)
    st.tmc[3:2] == 2'h3 && pins_out.match_a_irq);
  cov_square: cover property (@(posedge core_clk) disable iff (!rst_n)
    st.toc[1:0] == 2'h3 && $rose(pins_out.timer_out_pin));
  cov_match_b: cover property (@(posedge core_clk) disable iff (!rst_n)
    pins_out.match_b_irq);
  cov_ti_edge: cover property (@(posedge core_clk) disable iff (!rst_n)
    st.prm[2:0] == 3'h6 && tick);
endmodule
`default_nettype wire

// file: logic/iswt_pkg.sv
// Constants, types and register map of the interval and square wave timer
`default_nettype none
package iswt_pkg;
  localparam int          ISWT_AW      = 18;
  // Register indices; byte address is index times four
  localparam logic [15:0] IDX_PDIR     = 16'hff23;
  localparam logic [15:0] IDX_INSW     = 16'hff4f;
  localparam logic [15:0] IDX_PRM      = 16'hff50;
  localparam logic [15:0] IDX_TOC      = 16'hff51;
  localparam logic [15:0] IDX_TMC      = 16'hff52;
  localparam logic [15:0] IDX_CRA      = 16'hff53;
  localparam logic [15:0] IDX_CRB      = 16'hff54;
  localparam logic [15:0] IDX_CNT      = 16'hff55;
  localparam logic [7:0]  PDIR_RST     = 8'hff;
  localparam logic [7:0]  PDIR_FIXED   = 8'he1;
  localparam logic [7:0]  PDIR_WMASK   = 8'h1e;
  localparam logic [7:0]  INSW_RST     = 8'h00;
  localparam logic [7:0]  INSW_WMASK   = 8'h3f;
  localparam logic [7:0]  PRM_RST      = 8'h00;
  localparam logic [7:0]  PRM_WMASK    = 8'h37;
  localparam logic [7:0]  TOC_RST      = 8'h00;
  localparam logic [7:0]  TOC_WMASK    = 8'h13;
  localparam logic [7:0]  TMC_RST      = 8'h00;
  localparam logic [7:0]  TMC_WMASK    = 8'h0c;
  localparam int          INSW_IRQ0    = 0;
  localparam int          INSW_TI      = 1;
  localparam int          INSW_AUX     = 2;
  localparam int          INSW_RXEN    = 3;
  localparam int          INSW_SER_LO  = 4;
  localparam int          PRM_ES_LO    = 4;
  localparam int          TOC_TOE      = 0;
  localparam int          TOC_INV_A    = 1;
  localparam int          TOC_LVR      = 2;
  localparam int          TOC_LVS      = 3;
  localparam int          TOC_INV_B    = 4;
  localparam int          TMC_MODE_LO  = 2;
  localparam logic [1:0]  SER_PRIMARY  = 2'h0;
  localparam logic [1:0]  SER_ALT      = 2'h2;
  localparam logic [1:0]  ES_FALL      = 2'h0;
  localparam logic [1:0]  ES_RISE      = 2'h1;
  localparam logic [1:0]  ES_BOTH      = 2'h3;

  typedef enum logic [2:0] {
    CLK_FPRS, CLK_DIV2, CLK_DIV4, CLK_DIV16, CLK_DIV256,
    CLK_SUB, CLK_TI_EDGE, CLK_AUX_TIMER
  } iswt_clk_src_t;

  typedef enum logic [1:0] {
    MODE_STOP, MODE_FREE, MODE_EDGE_CLR, MODE_MATCH_CLR
  } iswt_mode_t;

  typedef struct packed {
    logic port3_pin3;
    logic port3_pin4;
    logic serial_pri_rx_pin;
    logic serial_alt_rx_pin;
    logic ext_irq0_pin;
    logic subsys_clk;
    logic aux_8bit_timer;
    logic gating_timer_output;
    logic serial_tx_output;
  } iswt_pin_in_t;

  typedef struct packed {
    logic [3:0] port3_oe;
    logic       timer_out_pin;
    logic       serial_pri_tx_pin;
    logic       serial_pri_tx_oe;
    logic       serial_alt_tx_pin;
    logic       serial_alt_tx_oe;
    logic       serial_rx_input;
    logic       ext_irq0_input;
    logic       aux_timer_input;
    logic       match_a_irq;
    logic       match_b_irq;
  } iswt_pin_out_t;
endpackage
`default_nettype wire

// file: verif/iswt_far_side.sv
// Far-side model: event sources and pin levels around the timer
`timescale 1ns/10ps
`default_nettype none
module iswt_far_side (
  // Clock
  input  wire logic              core_clk,
  // Levels towards the timer
  output iswt_pkg::iswt_pin_in_t pins_in
);
  import iswt_pkg::*;
  int cyc = 0;
  always_ff @(posedge core_clk) begin
    cyc <= cyc + 1;
  end
  // Every level held 3 cycles or more, so the two-sample filter sees it
  always_comb begin
    pins_in                     = '0;
    pins_in.port3_pin3          = (cyc % 10) < 5;
    pins_in.subsys_clk          = (cyc % 8) < 4;
    pins_in.aux_8bit_timer      = (cyc % 6) < 3;
    pins_in.serial_pri_rx_pin   = (cyc % 14) < 7;
    pins_in.port3_pin4          = 1'b1;
    pins_in.ext_irq0_pin        = 1'b1;
    pins_in.gating_timer_output = 1'b0;
  end
endmodule
`default_nettype wire

// file: verif/iswt_top_tb.sv
// Self-checking bench for the interval and square wave timer
`timescale 1ns/10ps
`default_nettype none
module iswt_top_tb;
  import iswt_pkg::*;
  logic               core_clk;
  logic               rst_n;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [ISWT_AW-1:0] paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic [31:0]        rdv;
  logic               pready;
  logic               pslverr;
  logic               err;
  iswt_pin_in_t       pins_in;
  iswt_pin_out_t      pins_out;
  int                 num_errors = 0;
  int                 tests_run = 0;

  iswt_top u_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins_in), .pins_out(pins_out));
  iswt_far_side u_far (.core_clk(core_clk), .pins_in(pins_in));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      final_report();
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] r);
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
  endtask

  // Cycles until the next match A pulse, bounded
  task automatic next_a(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pins_out.match_a_irq !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      num_errors++;
      final_report();
    end
  endtask

  task automatic t_regs();
    rd(IDX_PDIR, rdv);
    chk(rdv, 32'hff);
    chk(pins_out.port3_oe, 4'h0);
    rd(IDX_INSW, rdv);
    chk(rdv, 32'h0);
    wr(IDX_PDIR, 32'h0);
    rd(IDX_PDIR, rdv);
    chk(rdv, 32'he1);
    chk(pins_out.port3_oe, 4'hf);
    wr(IDX_PDIR, 32'hff);
    wr(IDX_INSW, 32'hff);
    rd(IDX_INSW, rdv);
    chk(rdv, 32'h3f);
    wr(IDX_INSW, 32'h0);
    apb(1'b0, 16'h0000, 32'h0, rdv, err);
    chk(err, 1'b1);
  endtask

  task automatic t_clk();
    int ex [8] = '{2, 4, 8, 32, 512, 16, 20, 12};
    int n;
    wr(IDX_CRA, 32'h1);
    wr(IDX_TMC, 32'hc);
    // Third pulse only: the first two may straddle the clock change
    for (int c = 0; c < 8; c++) begin
      wr(IDX_PRM, 32'(c));
      repeat (3) next_a(n);
      chk(n, ex[c]);
    end
    wr(IDX_PRM, 32'h6);
    wr(IDX_INSW, 32'h0a);
    repeat (3) next_a(n);
    chk(n, 28);
    wr(IDX_INSW, 32'h0);
  endtask

  task automatic t_sq();
    logic lv;
    int   n;
    int   nb;
    wr(IDX_PRM, 32'h0);
    wr(IDX_CRA, 32'h2);
    wr(IDX_CRB, 32'h1);
    wr(IDX_TOC, 32'h03);
    repeat (3) next_a(n);
    chk(n, 3);
    lv = pins_out.timer_out_pin;
    next_a(n);
    chk(pins_out.timer_out_pin, !lv);
    nb = 0;
    repeat (30) begin
      @(posedge core_clk);
      nb += pins_out.match_b_irq;
    end
    chk(nb, 10);
  endtask

  task automatic t_route();
    logic p;
    wr(IDX_INSW, 32'h09);
    repeat (2) @(posedge core_clk);
    p = pins_in.serial_pri_rx_pin;
    repeat (20) begin
      @(posedge core_clk);
      chk(pins_out.serial_rx_input, p);
      chk(pins_out.ext_irq0_input, p);
      p = pins_in.serial_pri_rx_pin;
    end
    chk(pins_out.serial_pri_tx_oe, 1'b1);
    chk(pins_out.serial_pri_tx_pin, 1'b0);
    chk(pins_out.serial_alt_tx_pin, 1'b1);
    chk(pins_out.aux_timer_input, 1'b1);
    wr(IDX_INSW, 32'h24);
    repeat (3) @(posedge core_clk);
    chk(pins_out.serial_rx_input, 1'b0);
    chk(pins_out.ext_irq0_input, 1'b1);
    chk(pins_out.serial_alt_tx_oe, 1'b1);
    chk(pins_out.serial_alt_tx_pin, 1'b0);
    chk(pins_out.serial_pri_tx_oe, 1'b0);
    chk(pins_out.aux_timer_input, 1'b0);
  endtask

  task automatic t_run();
    logic [31:0] a;
    int          n;
    wr(IDX_TMC, 32'h4);
    rd(IDX_CNT, a);
    rd(IDX_CNT, rdv);
    chk(rdv, a + 32'h3);
    wr(IDX_TMC, 32'h0);
    rd(IDX_CNT, rdv);
    chk(rdv, 32'h0);
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      n += pins_out.match_a_irq;
    end
    chk(n, 0);
  endtask

  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = 32'h0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_clk();
    t_sq();
    t_route();
    t_run();
    final_report();
  end
endmodule
`default_nettype wire
